// ---- aia_pkg.sv ----
// Package for the two-wire register access block of the converter.
// Holds pointer codes, configuration layout, conversion timing and the state record.
// Assumes a single 50 MHz system clock drives every consumer of these constants.
package aia_pkg;

    // System clock rate in hertz
    localparam int CLK_HZ = 50_000_000;

    // Bus address width and the default address (pins would select it)
    localparam int ADDR_W = 7;
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h48;

    // Pointer codes for the two registers
    localparam logic [7:0] PTR_RESULT = 8'h00;
    localparam logic [7:0] PTR_CONFIG = 8'h01;

    // Configuration field positions
    localparam int CFG_START_BIT = 15;
    localparam int CFG_MODE_BIT = 8;
    localparam int CFG_RATE_LSB = 5;
    localparam int CFG_RATE_W = 3;

    // Configuration reset value: single-shot, middle data rate
    localparam logic [15:0] CFG_RESET = 16'h0180;

    // Read value for a pointer that selects nothing
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // Saturation codes of the result
    localparam logic [15:0] CODE_POS_FULL = 16'h7fff;
    localparam logic [15:0] CODE_NEG_FULL = 16'h8000;

    // Data rates in samples per second, indexed by the rate field
    localparam int RATE_SPS [8] = '{8, 16, 32, 64, 128, 250, 475, 860};

    // Serial engine states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK
    } aia_state_t;

    // Whole state of the block
    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        aia_state_t st;
        logic [7:0] shreg;
        logic [3:0] bitcnt;
        logic [1:0] byte_idx;
        logic rw;
        logic nack;
        logic [7:0] pointer;
        logic [7:0] msb_hold;
        logic [15:0] tx_word;
        logic [15:0] cfg;
        logic [15:0] result;
        logic busy;
        logic pdown;
        logic [31:0] conv_cnt;
        logic sda_oe;
        logic sda_out;
    } aia_regs_t;

endpackage

// ---- aia_top.sv ----
// Two-wire slave giving access to the pointer, configuration and result registers,
// plus the single-shot and continuous conversion sequencer that fills the result.
// Assumes an external master clocks the bus; the line pair is open drain and the
// testbench resolves the wire from sda_oe. Analog inputs arrive as codes on ref_clk.
//
// Functional notes
// R1 - Single-shot: one conversion per request, stored
// R2 - After single-shot, drop into power-down state
// R3 - Continuous: restart conversion right after completion
// R4 - Continuous pace follows programmed data rate
// R5 - Result readable anytime, only whole conversions
// R6 - Master clocks bus; device only samples clock
// R7 - Master sends address plus read/write bit
// R8 - First written byte loads the pointer
// R9 - Two more bytes: MSB then LSB stored
// R10 - Master frames transfers with start, stop
// R11 - Pointer one is config, zero is result
// R12 - Reads return MSB then LSB
// R13 - Pointer kept between transfers
// R14 - Sixteen-bit two's complement, saturating at limits
`timescale 1ns/1ps

module aia_top #(
    parameter logic [6:0] DEV_ADDR = aia_pkg::DEV_ADDR_DEFAULT,
    parameter int CONV_DIV = 1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic signed [15:0] positive_analog_input,
    input wire logic signed [15:0] negative_analog_input,
    output logic conv_busy,
    output logic powered_down
);

    // Reset image of the whole state record
    localparam aia_pkg::aia_regs_t REGS_RESET = '{
        scl_m: 1'b1,
        scl_s: 1'b1,
        scl_p: 1'b1,
        sda_m: 1'b1,
        sda_s: 1'b1,
        sda_p: 1'b1,
        st: aia_pkg::ST_IDLE,
        shreg: 8'h00,
        bitcnt: 4'h0,
        byte_idx: 2'h0,
        rw: 1'b0,
        nack: 1'b0,
        pointer: aia_pkg::PTR_RESULT,
        msb_hold: 8'h00,
        tx_word: 16'h0000,
        cfg: aia_pkg::CFG_RESET,
        result: 16'h0000,
        busy: 1'b0,
        pdown: 1'b1,
        conv_cnt: 32'h0000_0000,
        sda_oe: 1'b0,
        sda_out: 1'b0
    };

    // Registered state and its next value
    aia_pkg::aia_regs_t s_q;
    aia_pkg::aia_regs_t s_d;

    // Conversion length in ref_clk cycles for a rate code; never below one cycle
    function automatic logic [31:0] conv_cycles(input logic [2:0] rate);
        int c;
        c = aia_pkg::CLK_HZ / (aia_pkg::RATE_SPS[rate] * CONV_DIV);
        if (c < 1) begin
            c = 1;
        end
        return 32'(c);
    endfunction

    // Clamp the input difference to the sixteen-bit code range
    function automatic logic [15:0] saturate(input logic signed [15:0] p, input logic signed [15:0] n);
        logic signed [16:0] diff;
        diff = 17'(p) - 17'(n);
        if (diff > 17'sd32767) begin
            return aia_pkg::CODE_POS_FULL;
        end else if (diff < -17'sd32768) begin
            return aia_pkg::CODE_NEG_FULL;
        end
        return diff[15:0];
    endfunction

    // Register read view; top config bit reads high while no conversion runs
    function automatic logic [15:0] read_view(input aia_pkg::aia_regs_t r);
        // R11 pointer selects register
        if (r.pointer == aia_pkg::PTR_CONFIG) begin
            return {~r.busy, r.cfg[14:0]};
        end else if (r.pointer == aia_pkg::PTR_RESULT) begin
            return r.result;
        end
        return aia_pkg::UNMAPPED_READ;
    endfunction

    // Next-state logic for the whole record
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_cond;
        logic stop_cond;
        logic cfg_write;
        logic [15:0] wdata;
        logic [7:0] next_byte;
        logic continuous;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_cond = 1'b0;
        stop_cond = 1'b0;
        cfg_write = 1'b0;
        wdata = 16'h0000;
        next_byte = 8'h00;
        continuous = 1'b0;
        // Every field holds unless a branch below changes it
        s_d = s_q;

        // R6 two-stage sampling
        s_d.scl_m = scl_in;
        s_d.scl_s = s_q.scl_m;
        s_d.scl_p = s_q.scl_s;
        s_d.sda_m = sda_in;
        s_d.sda_s = s_q.sda_m;
        s_d.sda_p = s_q.sda_s;
        // Open drain: the line is only ever pulled low
        s_d.sda_out = 1'b0;

        // Edges and bus conditions seen on the synchronised lines
        scl_rise = s_q.scl_s & ~s_q.scl_p;
        scl_fall = ~s_q.scl_s & s_q.scl_p;
        start_cond = s_q.scl_s & s_q.scl_p & ~s_q.sda_s & s_q.sda_p;
        stop_cond = s_q.scl_s & s_q.scl_p & s_q.sda_s & ~s_q.sda_p;

        // R10 start and stop framing
        if (start_cond) begin
            s_d.st = aia_pkg::ST_ADDR;
            s_d.bitcnt = 4'h0;
            s_d.sda_oe = 1'b0;
        end else if (stop_cond) begin
            s_d.st = aia_pkg::ST_IDLE;
            s_d.sda_oe = 1'b0;
        end else if (scl_rise) begin
            // Data is sampled while the clock is high
            case (s_q.st)
                aia_pkg::ST_ADDR,
                aia_pkg::ST_WR_BYTE: begin
                    s_d.shreg = {s_q.shreg[6:0], s_q.sda_s};
                    s_d.bitcnt = s_q.bitcnt + 4'h1;
                end
                aia_pkg::ST_RD_ACK: begin
                    s_d.nack = s_q.sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            // The line only changes while the clock is low
            case (s_q.st)
                aia_pkg::ST_ADDR: begin
                    if (s_q.bitcnt == 4'h8) begin
                        // R7 address match and direction bit
                        if (s_q.shreg[7:1] == DEV_ADDR) begin
                            s_d.st = aia_pkg::ST_ADDR_ACK;
                            s_d.rw = s_q.shreg[0];
                            s_d.sda_oe = 1'b1;
                            // R5 snapshot of whole word the pointer selects
                            s_d.tx_word = read_view(s_q);
                        end else begin
                            s_d.st = aia_pkg::ST_IDLE;
                        end
                    end
                end
                aia_pkg::ST_ADDR_ACK: begin
                    s_d.byte_idx = 2'h0;
                    if (s_q.rw) begin
                        // R12 most significant byte first
                        next_byte = s_q.tx_word[15:8];
                        s_d.sda_oe = ~next_byte[7];
                        s_d.shreg = {next_byte[6:0], 1'b0};
                        s_d.bitcnt = 4'h1;
                        s_d.byte_idx = 2'h1;
                        s_d.st = aia_pkg::ST_RD_BYTE;
                    end else begin
                        s_d.sda_oe = 1'b0;
                        s_d.bitcnt = 4'h0;
                        s_d.st = aia_pkg::ST_WR_BYTE;
                    end
                end
                aia_pkg::ST_WR_BYTE: begin
                    if (s_q.bitcnt == 4'h8) begin
                        s_d.sda_oe = 1'b1;
                        s_d.st = aia_pkg::ST_WR_ACK;
                        case (s_q.byte_idx)
                            // R8 R13 pointer loaded and retained
                            2'h0: s_d.pointer = s_q.shreg;
                            2'h1: s_d.msb_hold = s_q.shreg;
                            // R9 MSB then LSB committed together
                            2'h2: begin
                                if (s_q.pointer == aia_pkg::PTR_CONFIG) begin
                                    cfg_write = 1'b1;
                                    wdata = {s_q.msb_hold, s_q.shreg};
                                end
                            end
                            default: begin
                            end
                        endcase
                        // Bytes beyond the data word are acked and dropped
                        if (s_q.byte_idx != 2'h3) begin
                            s_d.byte_idx = s_q.byte_idx + 2'h1;
                        end
                    end
                end
                aia_pkg::ST_WR_ACK: begin
                    s_d.sda_oe = 1'b0;
                    s_d.bitcnt = 4'h0;
                    s_d.st = aia_pkg::ST_WR_BYTE;
                end
                aia_pkg::ST_RD_BYTE: begin
                    if (s_q.bitcnt == 4'h8) begin
                        // Release so the master can acknowledge
                        s_d.sda_oe = 1'b0;
                        s_d.st = aia_pkg::ST_RD_ACK;
                    end else begin
                        s_d.sda_oe = ~s_q.shreg[7];
                        s_d.shreg = {s_q.shreg[6:0], 1'b0};
                        s_d.bitcnt = s_q.bitcnt + 4'h1;
                    end
                end
                aia_pkg::ST_RD_ACK: begin
                    if (s_q.nack) begin
                        s_d.st = aia_pkg::ST_IDLE;
                    end else begin
                        // R12 alternate MSB and LSB on longer reads
                        next_byte = s_q.byte_idx[0] ? s_q.tx_word[7:0] : s_q.tx_word[15:8];
                        s_d.byte_idx = {1'b0, ~s_q.byte_idx[0]};
                        s_d.sda_oe = ~next_byte[7];
                        s_d.shreg = {next_byte[6:0], 1'b0};
                        s_d.bitcnt = 4'h1;
                        s_d.st = aia_pkg::ST_RD_BYTE;
                    end
                end
                default: begin
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end

        // R11 config store; start bit is an action, never stored
        if (cfg_write) begin
            s_d.cfg = wdata;
            s_d.cfg[aia_pkg::CFG_START_BIT] = 1'b0;
        end

        // Conversion sequencer; rate sampled when each conversion starts
        // Mode follows the freshly written config; a switch to single-shot lets the running conversion finish
        continuous = ~s_d.cfg[aia_pkg::CFG_MODE_BIT];
        if (s_q.busy) begin
            if (s_q.conv_cnt == 32'h0000_0001) begin
                // R14 R5 whole saturated code lands at once
                s_d.result = saturate(positive_analog_input, negative_analog_input);
                if (continuous) begin
                    // R3 R4 immediate restart at current rate
                    s_d.conv_cnt = conv_cycles(s_d.cfg[aia_pkg::CFG_RATE_LSB +: aia_pkg::CFG_RATE_W]);
                end else begin
                    // R2 single-shot ends in power-down
                    s_d.busy = 1'b0;
                    s_d.conv_cnt = 32'h0000_0000;
                end
            end else begin
                s_d.conv_cnt = s_q.conv_cnt - 32'h0000_0001;
            end
        end else if (continuous || (cfg_write && wdata[aia_pkg::CFG_START_BIT])) begin
            // R1 one conversion per single-shot request
            s_d.busy = 1'b1;
            s_d.conv_cnt = conv_cycles(s_d.cfg[aia_pkg::CFG_RATE_LSB +: aia_pkg::CFG_RATE_W]);
        end
        // R2 shutdown mirrors idle sequencer
        s_d.pdown = ~s_d.busy;
    end

    // Single register stage for the whole record
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= REGS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the record flops
    assign sda_out = s_q.sda_out;
    assign sda_oe = s_q.sda_oe;
    assign conv_busy = s_q.busy;
    assign powered_down = s_q.pdown;

endmodule

// ---- aia_props.sv ----
// Concurrent checks on the pins of the two-wire register block.
// Assumes it is bound to aia_top and sees only that module's ports.
`timescale 1ns/1ps
module aia_props #(
    parameter logic [6:0] DEV_ADDR = 7'h48,
    parameter int CONV_DIV = 1
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic signed [15:0] positive_analog_input,
    input wire logic signed [15:0] negative_analog_input,
    input wire logic conv_busy,
    input wire logic powered_down
);
    localparam int MIN_N = aia_pkg::CLK_HZ / (aia_pkg::RATE_SPS[7] * CONV_DIV);
    int run_q;
    int run_d;
    int hi_q;
    int hi_d;
    // Busy run length and bus-high time; bus high beyond a bit means idle
    assign run_d = (sys_rst || !conv_busy) ? 0 : run_q + 1;
    assign hi_d = (sys_rst || !scl_in) ? 0 : hi_q + 1;
    always_ff @(posedge ref_clk) begin
        run_q <= run_d;
        hi_q <= hi_d;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sda_out_low_a: assert property (sda_out == 1'b0) else $error("sda_out not low");
    pd_tracks_busy_a: assert property (powered_down == !conv_busy) else $error("shutdown flag wrong");
    rst_idle_state_a: assert property ($fell(sys_rst) |-> !sda_oe && powered_down)
        else $error("not idle after reset");
    busy_min_len_a: assert property ($fell(conv_busy) |-> run_q >= MIN_N - 2)
        else $error("conversion too short");
    busy_holds_a: assert property ($rose(conv_busy) |=> conv_busy [*8]) else $error("busy glitch");
    oe_on_scl_low_a: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
        else $error("sda changed late");
    bus_oe_stable_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda changed with clock high");
    idle_no_drive_a: assert property (hi_q > 12 |-> !sda_oe) else $error("drives idle bus");
endmodule

bind aia_top aia_props #(.DEV_ADDR(DEV_ADDR), .CONV_DIV(CONV_DIV)) u_props (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .positive_analog_input(positive_analog_input),
    .negative_analog_input(negative_analog_input), .conv_busy(conv_busy), .powered_down(powered_down)
);

// ---- aia_master.sv ----
// Bus master model: start, stop and bit-level byte transfers.
// Assumes a pulled-up data wire resolved outside; clock idles high between frames.
`timescale 1ns/1ps
module aia_master (
    input wire logic ref_clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // master makes every clock, 8 cycles a bit
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sda_low <= !b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        #1 r = sda;
        tick(2);
        scl <= 1'b0;
    endtask
    task automatic start();
        tick(2);
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask
    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // Last byte of a read is refused so the slave lets go
    task automatic rd_byte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(last, r);
    endtask
endmodule

// ---- aia_top_tb_top.sv ----
// Self-checking bench: register access over the two-wire bus and conversion sequencing.
// Assumes the master model in aia_master and a pull-up on the data wire.
`timescale 1ns/1ps
module aia_top_tb_top;
    localparam int DIV = 1000;
    localparam logic [6:0] DEV_A = aia_pkg::DEV_ADDR_DEFAULT;
    logic ref_clk;
    logic sys_rst = 1'b1;
    logic scl;
    logic m_low;
    logic sda_oe;
    logic sda_out;
    logic conv_busy;
    logic powered_down;
    logic signed [15:0] pos_code = 16'sh0000;
    logic signed [15:0] neg_code = 16'sh0000;
    int n_errors = 0;
    int samples_checked = 0;
    int busy_len = 0;
    int last_len = 0;
    // Wired-and with pull-up
    wire sda_w = !((sda_oe === 1'b1) || m_low);
    aia_top #(.CONV_DIV(DIV)) i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .positive_analog_input(pos_code), .negative_analog_input(neg_code),
        .conv_busy(conv_busy), .powered_down(powered_down)
    );
    aia_master u_m (.ref_clk(ref_clk), .scl(scl), .sda_low(m_low), .sda(sda_w));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Length of the last finished busy run
    always @(posedge ref_clk) begin
        if (conv_busy === 1'b1) busy_len <= busy_len + 1;
        else if (busy_len != 0) begin
            last_len <= busy_len;
            busy_len <= 0;
        end
    end
    function automatic logic [15:0] sat(input int d);
        return (d > 32767) ? 16'h7fff : ((d < -32768) ? 16'h8000 : 16'(d));
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // address and write bit, then pointer and data bytes
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, input int nb);
        logic k;
        u_m.start();
        u_m.wr_byte({a, 1'b0}, k);
        chk(16'(k), 16'(a == DEV_A), "address ack");
        for (int i = 0; i <= nb && a == DEV_A; i++) begin
            u_m.wr_byte((i == 0) ? p : ((i == 1) ? d[15:8] : d[7:0]), k);
            chk(16'(k), 16'h0001, "data ack");
        end
        u_m.stop();
    endtask
    task automatic rd_chk(input logic [15:0] exp);
        logic [15:0] w;
        logic k;
        u_m.start();
        u_m.wr_byte({DEV_A, 1'b1}, k);
        u_m.rd_byte(1'b0, w[15:8]);
        u_m.rd_byte(1'b1, w[7:0]);
        u_m.stop();
        chk(w, exp, "read word");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        repeat (80000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        int p;
        int n;
        int nc;
        logic [15:0] e;
        logic [15:0] prev;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd_chk(16'h0000);
        wr_reg(DEV_A, 8'h01, 16'h0000, 0);
        // Top config bit reads back high while no conversion runs
        rd_chk(aia_pkg::CFG_RESET | 16'h8000);
        wr_reg(DEV_A, 8'h01, 16'h45e0, 2);
        rd_chk(16'hc5e0);
        wr_reg(DEV_A, 8'h01, 16'h7700, 1);
        wr_reg(7'h49, 8'h01, 16'h0000, 2);
        rd_chk(16'hc5e0);
        wr_reg(DEV_A, 8'h00, 16'hbeef, 2);
        rd_chk(16'h0000);
        wr_reg(DEV_A, 8'h02, 16'h0000, 0);
        rd_chk(aia_pkg::UNMAPPED_READ);
        $display("test registers done");
        prev = 16'h0000;
        for (int r = 0; r < 8; r++) begin
            nc = aia_pkg::CLK_HZ / (aia_pkg::RATE_SPS[r] * DIV);
            p = (r == 0) ? 32767 : ((r == 1) ? -32768 : r * 300);
            n = (r == 0) ? -32768 : ((r == 1) ? 1 : 5);
            e = sat(p - n);
            pos_code <= 16'(p);
            neg_code <= 16'(n);
            wr_reg(DEV_A, 8'h01, 16'h8100 | 16'(r << 5), 2);
            wr_reg(DEV_A, 8'h00, 16'h0000, 0);
            if (r < 4) rd_chk(prev);
            for (int t = 0; t < 7000 && powered_down !== 1'b1; t++) @(posedge ref_clk);
            repeat (20) @(posedge ref_clk);
            chk(16'(last_len >= nc - 2 && last_len <= nc + 2), 16'h0001, "conversion length");
            chk(16'(powered_down), 16'h0001, "shutdown");
            rd_chk(e);
            prev = e;
        end
        $display("test single shot done");
        pos_code <= 16'sh0100;
        neg_code <= 16'sh0000;
        wr_reg(DEV_A, 8'h01, 16'h00e0, 2);
        wr_reg(DEV_A, 8'h00, 16'h0000, 0);
        chk(16'(powered_down), 16'h0000, "running");
        chk(16'(conv_busy), 16'h0001, "busy running");
        rd_chk(16'h0100);
        pos_code <= 16'sh0200;
        repeat (150) @(posedge ref_clk);
        rd_chk(16'h0200);
        wr_reg(DEV_A, 8'h01, 16'h01e0, 2);
        for (int t = 0; t < 200 && powered_down !== 1'b1; t++) @(posedge ref_clk);
        chk(16'(powered_down), 16'h0001, "stopped");
        chk(16'(sda_out), 16'h0000, "open drain level");
        $display("test continuous done");
        tally_and_finish();
    end
endmodule
